// ==== hdl/pmw_pkg.sv ====
// Constants, encodings and register map of the power-mode wake controller.
`default_nettype none
package pmw_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PREP_DELAY_NS = 10000;
  localparam int unsigned PREP_CYCLES = PREP_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned OST_OSC_CYCLES = 1024;
  localparam int unsigned PLL_LOCK_NS = 2000000;
  localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 18;

  // ==========================================================================
  // Power-managed modes; bit 2 set means code is not executing.
  localparam logic [2:0] PM_PRI_RUN = 3'h0;
  localparam logic [2:0] PM_SEC_RUN = 3'h1;
  localparam logic [2:0] PM_RC_RUN = 3'h2;
  localparam logic [2:0] PM_PRIMARY_CLOCKED_IDLE = 3'h4;
  localparam logic [2:0] PM_SEC_IDLE = 3'h5;
  localparam logic [2:0] PM_RC_IDLE = 3'h6;
  localparam logic [2:0] PM_SLEEP = 3'h7;

  // Primary oscillator types; bit 2 clear means a crystal needing start-up.
  localparam logic [2:0] OSC_LOW_POWER_CRYSTAL = 3'h0;
  localparam logic [2:0] OSC_STANDARD_CRYSTAL = 3'h1;
  localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL = 3'h2;
  localparam logic [2:0] OSC_HIGH_SPEED_PLL = 3'h3;
  localparam logic [2:0] OSC_EXTERNAL_CLOCK = 3'h4;
  localparam logic [2:0] OSC_EXTERNAL_RC = 3'h5;
  localparam logic [2:0] OSC_INTERNAL_SLOW = 3'h6;
  localparam logic [2:0] OSC_INTERNAL_FAST = 3'h7;

  // System clock select codes.
  localparam logic [1:0] CLK_PRIMARY = 2'h0;
  localparam logic [1:0] CLK_SECONDARY = 2'h1;
  localparam logic [1:0] CLK_INTERNAL = 2'h2;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [4:0] REG_OSC_CTRL = 5'h00;
  localparam logic [4:0] REG_INT_CTRL = 5'h04;
  localparam logic [4:0] REG_INT_EN = 5'h08;
  localparam logic [4:0] REG_CONFIG = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;

  localparam int unsigned FREQ_LSB = 4;
  localparam int unsigned PRI_READY_BIT = 3;
  localparam int unsigned INT_STABLE_BIT = 2;
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned CFG_TWO_SPEED_BIT = 3;
  localparam int unsigned CFG_FAIL_SAFE_BIT = 4;

  localparam logic [2:0] FREQ_RESET = 3'h0;
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam logic [2:0] CFG_OSC_RESET = 3'h2;

  typedef enum logic [4:0] {
    S_RST = 5'b0_0001,
    S_HOLD = 5'b0_0010,
    S_ACTIVE = 5'b0_0100,
    S_DOZE = 5'b0_1000,
    S_WAKE = 5'b1_0000
  } pmw_state_type;

endpackage
`default_nettype wire

// ==== hdl/pmw_timer_if.sv ====
// Control and status bundle between the wake controller and a delay timer.
`timescale 1ns/1ps
`default_nettype none
interface pmw_timer_if;
  logic start;
  logic stop;
  logic tick;
  logic [17:0] load;
  logic done;
  logic busy;
  modport ctrl (output start, output stop, output tick, output load, input done, input busy);
  modport timer (input start, input stop, input tick, input load, output done, output busy);
endinterface
`default_nettype wire

// ==== hdl/pmw_delay_timer.sv ====
// Down-counting delay timer advanced by an enable tick.
`timescale 1ns/1ps
`default_nettype none
module pmw_delay_timer
  import pmw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pmw_timer_if.timer tif
);

  logic [TMR_W-1:0] count;
  logic last;

  assign last = tif.busy && tif.tick && (count == 18'h0_0001);

  always_ff @(posedge clk) begin
    if (rst || tif.stop) begin
      count <= '0;
      tif.busy <= 1'b0;
      tif.done <= 1'b0;
    end else if (tif.start) begin
      count <= tif.load;
      tif.busy <= 1'b1;
      tif.done <= 1'b0;
    end else begin
      tif.done <= last;
      if (last) begin
        tif.busy <= 1'b0;
      end
      if (tif.busy && tif.tick) begin
        count <= count - 18'h0_0001;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/pmw_wake_ctrl.sv ====
// Wake-up, reset-exit and watchdog sequencing for the power-managed modes.
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_ctrl
  import pmw_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYC = PLL_LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] pm_mode,
  input wire logic [7:0] irq_flags,
  input wire logic watchdog_timeout,
  input wire logic reset_source,
  input wire logic osc_tick,
  input wire logic internal_osc_ready,
  input wire logic sleep_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic clock_lost,
  output logic cpu_reset_hold,
  output logic core_clock_en,
  output logic exec_en,
  output logic [1:0] clk_sel,
  output logic primary_osc_en,
  output logic wake_pulse,
  output logic vector_branch,
  output logic watchdog_reset,
  output logic watchdog_clear
);

  // ==========================================================================
  // Registers and state
  pmw_state_type state;
  logic [2:0] internal_freq_select;
  logic global_interrupt_enable;
  logic [7:0] int_en;
  logic [2:0] cfg_osc;
  logic cfg_two_speed;
  logic cfg_fail_safe;
  logic primary_clock_ready_flag;
  logic internal_osc_stable_flag;
  logic pri_on;
  logic prep_over;
  logic osc_over;
  logic pll_phase;
  logic [2:0] cap_mode;
  logic [2:0] cap_osc;
  logic wake_by_wdt;
  logic wake_by_irq;
  logic ack;

  pmw_timer_if prep_if ();
  pmw_timer_if osc_if ();

  pmw_delay_timer u_prep_timer (
    .clk(clk),
    .rst(rst),
    .tif(prep_if)
  );

  pmw_delay_timer u_osc_timer (
    .clk(clk),
    .rst(rst),
    .tif(osc_if)
  );

  // ==========================================================================
  // Wake decisions
  wire irq_hit = |(irq_flags & int_en);
  wire doze_trigger = irq_hit | watchdog_timeout;
  wire cfg_crystal = ~cfg_osc[2];
  wire need_ost = cfg_crystal && (pm_mode != PM_PRIMARY_CLOCKED_IDLE);
  wire need_prep = !((pm_mode == PM_RC_IDLE) && (cfg_osc == OSC_INTERNAL_FAST));
  wire rst_exit = (state == S_RST) && !reset_source;
  wire wake_go = (state == S_DOZE) && doze_trigger;
  wire low_run = (pm_mode == PM_SEC_RUN) || (pm_mode == PM_RC_RUN);
  wire run_wake = (state == S_ACTIVE) && low_run && irq_hit;
  wire run_wdt = (state == S_ACTIVE) && !pm_mode[2] && watchdog_timeout;
  wire enter_pm = (state == S_ACTIVE) && pm_mode[2] && !watchdog_timeout;
  wire early_pm = enter_pm && osc_if.busy;
  wire pll_next = osc_if.done && !pll_phase && (cap_osc == OSC_HIGH_SPEED_PLL);
  wire osc_end = osc_if.done && !pll_next;
  wire prep_end = prep_over || prep_if.done;
  wire wake_clocked = (cap_mode != PM_SLEEP) || cfg_two_speed;
  wire wake_done = (state == S_WAKE) && prep_end && (osc_over || osc_end);

  // ==========================================================================
  // Timer control
  assign prep_if.start = wake_go && need_prep;
  assign prep_if.stop = 1'b0;
  assign prep_if.tick = 1'b1;
  assign prep_if.load = TMR_W'(PREP_CYCLES);
  assign osc_if.start = (rst_exit && cfg_crystal) || ((wake_go || run_wake) && need_ost) || pll_next;
  assign osc_if.stop = early_pm;
  assign osc_if.tick = pll_phase ? 1'b1 : osc_tick;
  assign osc_if.load = pll_next ? TMR_W'(PLL_LOCK_CYC) : TMR_W'(OST_OSC_CYCLES);

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_RST;
      primary_clock_ready_flag <= 1'b0;
      pri_on <= 1'b0;
      prep_over <= 1'b0;
      osc_over <= 1'b0;
      cap_mode <= PM_PRI_RUN;
      cap_osc <= OSC_LOW_POWER_CRYSTAL;
      wake_by_wdt <= 1'b0;
      wake_by_irq <= 1'b0;
      wake_pulse <= 1'b0;
      vector_branch <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      vector_branch <= 1'b0;
      watchdog_reset <= 1'b0;
      case (state)
        S_RST: begin
          if (!reset_source) begin
            cap_osc <= cfg_osc;
            cap_mode <= PM_PRI_RUN;
            pri_on <= 1'b1;
            if (cfg_crystal && !(cfg_two_speed || cfg_fail_safe)) begin
              state <= S_HOLD;
            end else begin
              state <= S_ACTIVE;
              primary_clock_ready_flag <= !cfg_crystal && (cfg_osc != OSC_INTERNAL_FAST);
            end
          end
        end
        S_HOLD: begin
          if (osc_end) begin
            primary_clock_ready_flag <= 1'b1;
            state <= S_ACTIVE;
          end
        end
        S_ACTIVE: begin
          if (osc_end) begin
            primary_clock_ready_flag <= 1'b1;
          end
          if (run_wdt) begin
            watchdog_reset <= 1'b1;
            state <= S_RST;
          end else if (enter_pm) begin
            pri_on <= (pm_mode == PM_PRIMARY_CLOCKED_IDLE) && !osc_if.busy;
            primary_clock_ready_flag <= primary_clock_ready_flag && (pm_mode == PM_PRIMARY_CLOCKED_IDLE);
            state <= S_DOZE;
          end else if (run_wake) begin
            cap_mode <= pm_mode;
            cap_osc <= cfg_osc;
            wake_pulse <= 1'b1;
            wake_by_irq <= 1'b1;
            wake_by_wdt <= 1'b0;
            vector_branch <= global_interrupt_enable;
            prep_over <= 1'b1;
            osc_over <= !need_ost;
            pri_on <= 1'b1;
            state <= S_WAKE;
          end
        end
        S_DOZE: begin
          if (wake_go) begin
            cap_mode <= pm_mode;
            cap_osc <= cfg_osc;
            wake_pulse <= 1'b1;
            wake_by_irq <= irq_hit;
            wake_by_wdt <= !irq_hit;
            vector_branch <= irq_hit && global_interrupt_enable;
            prep_over <= !need_prep;
            osc_over <= !need_ost;
            pri_on <= 1'b1;
            state <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (prep_if.done) begin
            prep_over <= 1'b1;
          end
          if (osc_end) begin
            osc_over <= 1'b1;
          end
          if (wake_done) begin
            primary_clock_ready_flag <= (cap_osc != OSC_INTERNAL_FAST);
            state <= S_ACTIVE;
          end
        end
        default: begin
          state <= S_RST;
        end
      endcase
    end
  end

  // The PLL lock wait follows the start-up timer in the same counter.
  always_ff @(posedge clk) begin
    if (rst || osc_if.stop) begin
      pll_phase <= 1'b0;
    end else if (pll_next) begin
      pll_phase <= 1'b1;
    end else if (osc_if.start || osc_end) begin
      pll_phase <= 1'b0;
    end
  end

  // ==========================================================================
  // Clocking outputs
  function automatic logic [1:0] mode_clock(input logic [2:0] mode);
    logic [1:0] sel;
    sel = CLK_INTERNAL;
    if (mode == PM_PRIMARY_CLOCKED_IDLE || mode == PM_PRI_RUN) begin
      sel = CLK_PRIMARY;
    end else if (mode == PM_SEC_IDLE || mode == PM_SEC_RUN) begin
      sel = CLK_SECONDARY;
    end
    return sel;
  endfunction

  wire active_sel = (state == S_ACTIVE);
  wire wake_sel = (state == S_WAKE);

  assign cpu_reset_hold = (state == S_RST) || (state == S_HOLD);
  assign core_clock_en = active_sel || (wake_sel && wake_clocked);
  assign exec_en = active_sel || (wake_sel && wake_clocked && prep_over);
  assign primary_osc_en = pri_on;
  assign clk_sel = (active_sel && osc_if.busy) ? CLK_INTERNAL :
                   active_sel ? (low_run ? mode_clock(pm_mode) : CLK_PRIMARY) :
                   (wake_sel && osc_over) ? CLK_PRIMARY :
                   wake_sel ? mode_clock(cap_mode) :
                   (state == S_DOZE) ? mode_clock(pm_mode) : CLK_INTERNAL;

  // Stable flag only means something when the fast output is enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_osc_stable_flag <= 1'b0;
    end else begin
      internal_osc_stable_flag <= internal_osc_ready && (internal_freq_select != FREQ_RESET);
    end
  end

  // ==========================================================================
  // Avalon-MM slave: one wait state, answer on the second edge.
  wire req = (avs_read || avs_write) && !ack;
  wire sel_osc = (avs_address == REG_OSC_CTRL);
  wire sel_int = (avs_address == REG_INT_CTRL);
  wire sel_en = (avs_address == REG_INT_EN);
  wire sel_cfg = (avs_address == REG_CONFIG);
  wire sel_sts = (avs_address == REG_STATUS);
  wire wr_ok = avs_write && ack && avs_byteenable[0];
  wire [2:0] wr_freq = avs_writedata[FREQ_LSB+2:FREQ_LSB];
  wire freq_change = wr_ok && sel_osc && (wr_freq != internal_freq_select) && (clk_sel == CLK_INTERNAL);

  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state == S_RST) begin
      internal_freq_select <= FREQ_RESET;
    end else if (wr_ok && sel_osc) begin
      internal_freq_select <= wr_freq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      global_interrupt_enable <= 1'b0;
      int_en <= INT_EN_RESET;
      cfg_osc <= CFG_OSC_RESET;
      cfg_two_speed <= 1'b0;
      cfg_fail_safe <= 1'b0;
    end else if (wr_ok && sel_int) begin
      global_interrupt_enable <= avs_writedata[GIE_BIT];
    end else if (wr_ok && sel_en) begin
      int_en <= avs_writedata[7:0];
    end else if (wr_ok && sel_cfg) begin
      cfg_osc <= avs_writedata[2:0];
      cfg_two_speed <= avs_writedata[CFG_TWO_SPEED_BIT];
      cfg_fail_safe <= avs_writedata[CFG_FAIL_SAFE_BIT];
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_osc) begin
      rd_mux = {25'h0, internal_freq_select, primary_clock_ready_flag, internal_osc_stable_flag, clk_sel};
    end else if (sel_int) begin
      rd_mux = {24'h0, global_interrupt_enable, 7'h0};
    end else if (sel_en) begin
      rd_mux = {24'h0, int_en};
    end else if (sel_cfg) begin
      rd_mux = {27'h0, cfg_fail_safe, cfg_two_speed, cfg_osc};
    end else if (sel_sts) begin
      rd_mux = {19'h0, wake_by_irq, wake_by_wdt, cap_osc, cap_mode, state};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && req) begin
      avs_readdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Watchdog clear events
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= sleep_instruction || watchdog_clear_instruction ||
                        (clock_lost && cfg_fail_safe) || freq_change;
    end
  end

endmodule
`default_nettype wire

// ==== bench/pmw_osc_model.sv ====
// Behavioural oscillator sources beside the wake controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_osc_model
  import pmw_pkg::*;
#(
  parameter int unsigned STABLE_CYC = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic primary_osc_en,
  output logic osc_tick,
  output logic internal_osc_ready
);
  // ==========================================================================
  // Oscillators
  // The crystal runs at half the system rate and is silent while disabled.
  logic [4:0] settle;
  always_ff @(posedge clk) begin
    if (rst || !primary_osc_en) begin
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= !osc_tick;
    end
  end
  // The fast internal source needs a while after reset to settle.
  always_ff @(posedge clk) begin
    if (rst) begin
      settle <= 5'h00;
    end else if (settle != 5'h1F) begin
      settle <= settle + 5'h01;
    end
  end
  assign internal_osc_ready = (32'(settle) >= STABLE_CYC);
endmodule
`default_nettype wire

// ==== bench/pmw_wake_ctrl_asserts.sv ====
// Port checker for the power-mode wake controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_ctrl_asserts
  import pmw_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYC = PLL_LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [2:0] pm_mode,
  input wire logic [7:0] irq_flags,
  input wire logic watchdog_timeout,
  input wire logic sleep_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic cpu_reset_hold,
  input wire logic exec_en,
  input wire logic [1:0] clk_sel,
  input wire logic wake_pulse,
  input wire logic vector_branch,
  input wire logic watchdog_reset,
  input wire logic watchdog_clear
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wake_cause_a: assert property (wake_pulse |-> ($past(irq_flags) != 8'h00) || $past(watchdog_timeout))
    else $error("wake pulse without a trigger");
  vector_wake_a: assert property (vector_branch |-> wake_pulse)
    else $error("vector branch outside a wake");
  wake_single_a: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than one cycle");
  run_wdt_a: assert property (watchdog_reset |-> $past(watchdog_timeout) && !$past(pm_mode[2]))
    else $error("watchdog reset without run-mode time-out");
  sleep_wdt_a: assert property (watchdog_timeout && pm_mode[2] && !cpu_reset_hold |=> !watchdog_reset)
    else $error("watchdog reset while not executing");
  wdt_internal_a: assert property (watchdog_reset |=> cpu_reset_hold && clk_sel == CLK_INTERNAL)
    else $error("watchdog reset did not select internal clock");
  wdt_clear_a: assert property (sleep_instruction || watchdog_clear_instruction |=> watchdog_clear)
    else $error("watchdog not cleared");
  hold_no_exec_a: assert property (cpu_reset_hold |-> !exec_en)
    else $error("execution while held in reset");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule
bind pmw_wake_ctrl pmw_wake_ctrl_asserts #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_chk (.clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .pm_mode, .irq_flags, .watchdog_timeout, .sleep_instruction, .watchdog_clear_instruction,
  .cpu_reset_hold, .exec_en, .clk_sel, .wake_pulse, .vector_branch, .watchdog_reset, .watchdog_clear);
`default_nettype wire

// ==== bench/pmw_wake_ctrl_tb.sv ====
// Self-checking testbench for the power-mode wake controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_ctrl_tb;
  import pmw_pkg::*;
  // ==========================================================================
  // Wiring
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] pm_mode = PM_PRI_RUN;
  logic [7:0] irq_flags = 8'h00;
  logic watchdog_timeout = 1'b0;
  logic reset_source = 1'b1;
  logic sleep_instruction = 1'b0;
  logic watchdog_clear_instruction = 1'b0;
  logic clock_lost = 1'b0;
  logic osc_tick, internal_osc_ready, cpu_reset_hold, core_clock_en, exec_en, primary_osc_en;
  logic wake_pulse, vector_branch, watchdog_reset, watchdog_clear;
  logic [1:0] clk_sel;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  // A short lock count keeps the run brief; expectations use the same value.
  pmw_wake_ctrl #(.PLL_LOCK_CYC(50)) i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pm_mode, .irq_flags, .watchdog_timeout,
    .reset_source, .osc_tick, .internal_osc_ready, .sleep_instruction, .watchdog_clear_instruction,
    .clock_lost, .cpu_reset_hold, .core_clock_en, .exec_en, .clk_sel, .primary_osc_en, .wake_pulse,
    .vector_branch, .watchdog_reset, .watchdog_clear);
  pmw_osc_model i_osc (.clk, .rst, .primary_osc_en, .osc_tick, .internal_osc_ready);
  // ==========================================================================
  // Helpers
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  // Bus cycle: the request holds until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) timeout();
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== v && n < lim);
  endtask
  task automatic wait_active();
    int i;
    i = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      i++;
      if (i > 100) timeout();
    end while (q[4:0] !== S_ACTIVE);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    int n;
    int ticks;
    n = 0;
    ticks = 0;
    while (cpu_reset_hold !== 1'b0) begin
      @(negedge clk);
      if (osc_tick === 1'b1) ticks++;
      n++;
      if (n > 5000) timeout();
    end
    chk(32'(ticks >= OST_OSC_CYCLES && ticks <= OST_OSC_CYCLES + 2), 32'h1);
    bus(1'b0, REG_OSC_CTRL, 32'h0000_0000);
    chk(32'(q[PRI_READY_BIT]), 32'h1);
    chk(32'(q[6:4]), 32'(FREQ_RESET));
    bus(1'b0, REG_CONFIG, 32'h0000_0000);
    chk(32'(q[2:0]), 32'(CFG_OSC_RESET));
  endtask
  task automatic t_regs();
    bus(1'b1, REG_OSC_CTRL, 32'h0000_0030);
    bus(1'b0, REG_OSC_CTRL, 32'h0000_0000);
    chk(32'(q[6:4]), 32'h3);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_clear();
    for (int i = 0; i < 4; i++) begin
      if (i == 3) bus(1'b1, REG_CONFIG, 32'h0000_0012);
      @(posedge clk);
      sleep_instruction <= (i == 0);
      watchdog_clear_instruction <= (i == 1);
      clock_lost <= (i >= 2);
      @(posedge clk);
      sleep_instruction <= 1'b0;
      watchdog_clear_instruction <= 1'b0;
      clock_lost <= 1'b0;
      #1 chk(32'(watchdog_clear), 32'(i != 2));
    end
    @(posedge clk);
    pm_mode <= PM_RC_RUN;
    bus(1'b1, REG_OSC_CTRL, 32'h0000_0050);
    #1 chk(32'(watchdog_clear), 32'h1);
    @(posedge clk);
    pm_mode <= PM_PRI_RUN;
  endtask
  // Sleep, a disabled flag that must not wake, then the real trigger.
  task automatic t_wake(input logic gie, input logic wdt, input logic [2:0] osc, input logic [2:0] mode,
                        input int lo, input int hi);
    int n;
    bus(1'b1, REG_INT_EN, 32'h0000_0001);
    bus(1'b1, REG_INT_CTRL, 32'(gie) << GIE_BIT);
    bus(1'b1, REG_CONFIG, 32'(osc));
    @(posedge clk);
    pm_mode <= mode;
    irq_flags <= 8'h02;
    wait_lvl(wake_pulse, 1'b1, 30, n);
    chk(32'(n), 32'd30);
    chk(32'(exec_en), 32'h0);
    chk(32'(primary_osc_en), 32'(mode == PM_PRIMARY_CLOCKED_IDLE));
    @(posedge clk);
    irq_flags <= wdt ? 8'h02 : 8'h03;
    watchdog_timeout <= wdt;
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    wait_lvl(wake_pulse, 1'b1, 50, n);
    chk(32'(n < 50), 32'h1);
    chk(32'(vector_branch), 32'(gie && !wdt));
    chk(32'(core_clock_en), 32'(mode != PM_SLEEP));
    // Leave the mode while still waking, or the controller dozes again on arrival in run.
    @(posedge clk);
    pm_mode <= PM_PRI_RUN;
    irq_flags <= 8'h00;
    wait_lvl(exec_en, 1'b1, 4000, n);
    chk(32'(n >= lo && n <= hi), 32'h1);
    wait_active();
    bus(1'b0, REG_OSC_CTRL, 32'h0000_0000);
    chk(32'(q[PRI_READY_BIT]), 32'(osc != OSC_INTERNAL_FAST));
    chk(32'(q[INT_STABLE_BIT]), 32'h1);
  endtask
  task automatic t_wdt_run();
    int n;
    @(posedge clk);
    watchdog_timeout <= 1'b1;
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    #1 chk(32'(watchdog_reset), 32'h1);
    wait_lvl(cpu_reset_hold, 1'b0, 4000, n);
    chk(32'(n < 4000), 32'h1);
    bus(1'b0, REG_OSC_CTRL, 32'h0000_0000);
    chk(32'(q[6:4]), 32'(FREQ_RESET));
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reset_source <= 1'b0;
    t_reset();
    t_regs();
    t_clear();
    t_wake(1'b0, 1'b0, OSC_EXTERNAL_CLOCK, PM_SLEEP, PREP_CYCLES + 1, PREP_CYCLES + 1);
    t_wake(1'b1, 1'b0, OSC_EXTERNAL_CLOCK, PM_SLEEP, PREP_CYCLES + 1, PREP_CYCLES + 1);
    t_wake(1'b0, 1'b0, OSC_INTERNAL_FAST, PM_RC_IDLE, 1, 1);
    t_wake(1'b1, 1'b1, OSC_HIGH_SPEED_PLL, PM_SLEEP, 2000, 2999);
    t_wdt_run();
    finish_test();
  end
endmodule
`default_nettype wire
